// ### tx_path_pkg.sv
// constants for the transmit command, data and status path
package tx_path_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_DATA   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CFG    = 8'h08;
   localparam logic [7:0] OFS_INFO   = 8'h0C;
   localparam int CFG_DISCARD_BIT = 0;
   localparam int INFO_ERR_BIT    = 0;
   localparam int INFO_USED_LSB   = 8;
   localparam logic CFG_RESET     = 1'b0;
   // first command word fields
   localparam int A_SIZE_LSB  = 0;
   localparam int A_LAST_BIT  = 12;
   localparam int A_FIRST_BIT = 13;
   localparam int A_OFF_LSB   = 16;
   localparam int A_ALIGN_LSB = 24;
   // second command word fields
   localparam int B_LEN_LSB   = 0;
   localparam int B_NOPAD_BIT = 12;
   localparam int B_NOCRC_BIT = 13;
   localparam int B_TAG_LSB   = 16;
   // status word fields
   localparam int S_DEF_BIT   = 0;
   localparam int S_EXDEF_BIT = 2;
   localparam int S_CC_LSB    = 3;
   localparam int S_EXCOL_BIT = 8;
   localparam int S_LATE_BIT  = 9;
   localparam int S_NOCAR_BIT = 10;
   localparam int S_LOST_BIT  = 11;
   localparam int S_ES_BIT    = 15;
   localparam int S_TAG_LSB   = 16;
   // status queue
   localparam int STAT_DEPTH = 4;
   localparam int STAT_AW    = 2;
   localparam logic [STAT_AW:0] STAT_FULL = 3'h4;
   typedef enum logic [1:0] {ALIGN_4, ALIGN_16, ALIGN_32, ALIGN_RSVD} align_e;
endpackage : tx_path_pkg

// ### tx_command_data_status_path.sv
// transmit command parser, payload extractor and status queue with apb registers
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module tx_command_data_status_path
   import tx_path_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic      [31:0] mac_data,
   output logic      [3:0]  mac_be,
   output logic             mac_valid,
   output logic             mac_last,
   output logic             mac_no_crc,
   output logic             mac_no_pad,
   input  wire logic        mac_ready,
   input  wire logic        mac_done,
   input  wire logic        mac_lost_carrier,
   input  wire logic        mac_no_carrier,
   input  wire logic        mac_late_col,
   input  wire logic        mac_excess_col,
   input  wire logic [3:0]  mac_col_count,
   input  wire logic        mac_excess_defer,
   input  wire logic        mac_deferred,
   input  wire logic        defer_check_enable,
   output logic             transmit_error_flag,
   output logic      [2:0]  status_fifo_used_count
);
   typedef enum {S_CMDA, S_CMDB, S_SKIP, S_DATA, S_PAD} parse_e;

   parse_e            st_r;
   logic [31:0]       cmda_r;
   logic [31:0]       cmdb_r;
   logic [10:0]       sum_r;
   logic [10:0]       cnt_r;
   logic [10:0]       data_cnt_r;
   logic [10:0]       pad_cnt_r;
   logic              first_r;
   logic              await_r;
   logic [15:0]       tag_r;
   logic              discard_r;
   logic              err_r;
   logic              ovr_r;
   logic [31:0]       stat_mem [STAT_DEPTH];
   logic [STAT_AW-1:0] wr_ptr_r;
   logic [STAT_AW-1:0] rd_ptr_r;
   logic [STAT_AW:0]  count_r;
   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [31:0]       mac_data_r;
   logic [3:0]        mac_be_r;
   logic              mac_valid_r;
   logic              mac_last_r;
   logic              no_crc_r;
   logic              no_pad_r;
   logic [2:0]        used_r;

   // dwords the buffer occupies including its start offset dwords, rounded to alignment
   function automatic logic [10:0] aligned_words(input logic [10:0] used, input logic [1:0] al);
      logic [10:0] m;
      m = 11'h001;
      unique case (align_e'(al))
         ALIGN_16: m = 11'h004;
         ALIGN_32: m = 11'h008;
         default:  m = 11'h001;
      endcase
      return (used + m - 11'h001) & ~(m - 11'h001);
   endfunction : aligned_words

   //////////////////////////////////////////////////////////////////////////////
   // apb decode
   logic        acc;
   logic        done_x;
   logic        wr_data;
   logic        full;
   logic        suspend;
   logic        mapped;
   logic        can_take;
   assign acc      = psel && penable;
   assign done_x   = acc && pready_r;
   assign full     = (count_r == STAT_FULL);
   assign suspend  = full && !discard_r;
   assign mapped   = (paddr == OFS_DATA) || (paddr == OFS_STATUS) || (paddr == OFS_CFG) || (paddr == OFS_INFO);
   // data writes stall while a packet awaits its status so tags cannot overtake
   assign can_take = !(pwrite && paddr == OFS_DATA) || (!mac_valid_r && !await_r && !suspend);
   assign wr_data  = done_x && pwrite && (paddr == OFS_DATA) && !pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= acc && !pready_r && (can_take || !mapped);
         pslverr_r <= acc && !pready_r && !mapped;
         prdata_r  <= 32'h0000_0000;
         if (acc && !pready_r && !pwrite) begin
            unique case (paddr)
               OFS_STATUS: prdata_r <= (count_r != '0) ? stat_mem[rd_ptr_r] : 32'h0000_0000;
               OFS_CFG:    prdata_r <= {31'h0000_0000, discard_r};
               OFS_INFO:   prdata_r <= {21'h00_0000, used_r, 7'h00, err_r};
               default:    prdata_r <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         discard_r <= CFG_RESET;
      end else if (done_x && pwrite && paddr == OFS_CFG) begin
         discard_r <= pwdata[CFG_DISCARD_BIT];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // buffer parser
   logic [10:0] sz;
   logic [11:0] span;
   logic [10:0] dw;
   logic [10:0] used;
   logic [10:0] pad;
   logic [10:0] sum_nxt;
   logic        len_bad;
   assign sz      = cmda_r[A_SIZE_LSB +: 11];
   assign span    = {1'b0, sz} + {10'h000, cmda_r[A_OFF_LSB +: 2]};
   assign dw      = span[11:2] + {10'h000, (span[1:0] != 2'h0)};
   assign used    = dw + {8'h00, cmda_r[A_OFF_LSB+2 +: 3]};
   assign pad     = aligned_words(used, cmda_r[A_ALIGN_LSB +: 2]) - used;
   assign sum_nxt = (cmda_r[A_FIRST_BIT] ? 11'h000 : sum_r) + sz;
   assign len_bad = cmda_r[A_LAST_BIT] && (sum_nxt != pwdata[B_LEN_LSB +: 11]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= S_CMDA;
         cmda_r     <= 32'h0000_0000;
         cmdb_r     <= 32'h0000_0000;
         sum_r      <= 11'h000;
         cnt_r      <= 11'h000;
         data_cnt_r <= 11'h000;
         pad_cnt_r  <= 11'h000;
         first_r    <= 1'b0;
      end else if (wr_data) begin
         unique case (st_r)
            S_CMDA: begin
               cmda_r <= pwdata;
               st_r   <= S_CMDB;
            end
            S_CMDB: begin
               cmdb_r     <= pwdata;
               sum_r      <= sum_nxt;
               data_cnt_r <= dw;
               pad_cnt_r  <= pad;
               first_r    <= 1'b1;
               cnt_r      <= (cmda_r[A_OFF_LSB+2 +: 3] != 3'h0) ? {8'h00, cmda_r[A_OFF_LSB+2 +: 3]} :
                             ((dw != 11'h000) ? dw : pad);
               if (cmda_r[A_OFF_LSB+2 +: 3] != 3'h0) st_r <= S_SKIP;
               else if (dw != 11'h000) st_r <= S_DATA;
               else if (pad != 11'h000) st_r <= S_PAD;
               else st_r <= S_CMDA;
            end
            S_SKIP: begin
               cnt_r <= cnt_r - 11'h001;
               if (cnt_r == 11'h001) begin
                  st_r  <= (data_cnt_r != 11'h000) ? S_DATA : ((pad_cnt_r != 11'h000) ? S_PAD : S_CMDA);
                  cnt_r <= (data_cnt_r != 11'h000) ? data_cnt_r : pad_cnt_r;
               end
            end
            S_DATA: begin
               first_r <= 1'b0;
               cnt_r   <= cnt_r - 11'h001;
               if (cnt_r == 11'h001) begin
                  st_r  <= (pad_cnt_r != 11'h000) ? S_PAD : S_CMDA;
                  cnt_r <= pad_cnt_r;
               end
            end
            S_PAD: begin
               cnt_r <= cnt_r - 11'h001;
               if (cnt_r == 11'h001) st_r <= S_CMDA;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // words toward the mac
   logic [3:0] lanes;
   always_comb begin
      lanes = 4'hF;
      if (first_r) lanes = 4'((4'hF << cmda_r[A_OFF_LSB +: 2]));
      if (cnt_r == 11'h001 && span[1:0] != 2'h0) lanes = lanes & ~4'((4'hF << span[1:0]));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mac_valid_r <= 1'b0;
         mac_data_r  <= 32'h0000_0000;
         mac_be_r    <= 4'h0;
         mac_last_r  <= 1'b0;
         no_crc_r    <= 1'b0;
         no_pad_r    <= 1'b0;
      end else if (wr_data && st_r == S_DATA) begin
         mac_valid_r <= 1'b1;
         mac_data_r  <= pwdata;
         mac_be_r    <= lanes;
         mac_last_r  <= (cnt_r == 11'h001) && cmda_r[A_LAST_BIT];
         no_crc_r    <= cmdb_r[B_NOCRC_BIT] && !cmdb_r[B_NOPAD_BIT];
         no_pad_r    <= cmdb_r[B_NOPAD_BIT];
      end else if (mac_ready) begin
         mac_valid_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         await_r <= 1'b0;
         tag_r   <= 16'h0000;
      end else begin
         if (mac_valid_r && mac_ready && mac_last_r) begin
            await_r <= 1'b1;
            tag_r   <= cmdb_r[B_TAG_LSB +: 16];
         end else if (mac_done) begin
            await_r <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // status word and status queue
   logic [31:0] stat_w;
   logic        push;
   logic        pop;
   logic        cmdb_bad;
   always_comb begin
      stat_w = 32'h0000_0000;
      stat_w[S_TAG_LSB +: 16] = tag_r;
      stat_w[S_LOST_BIT]  = mac_lost_carrier;
      stat_w[S_NOCAR_BIT] = mac_no_carrier;
      stat_w[S_LATE_BIT]  = mac_late_col;
      stat_w[S_EXCOL_BIT] = mac_excess_col;
      stat_w[S_CC_LSB +: 4] = mac_col_count;
      stat_w[S_EXDEF_BIT] = mac_excess_defer && defer_check_enable;
      stat_w[S_DEF_BIT]   = mac_deferred;
      stat_w[S_ES_BIT]    = |{stat_w[11:8], stat_w[2:1]};
   end

   assign push     = mac_done && await_r && !full && !ovr_r;
   assign pop      = done_x && !pwrite && paddr == OFS_STATUS && count_r != '0;
   assign cmdb_bad = !cmda_r[A_FIRST_BIT] && (pwdata != cmdb_r);
   always_ff @(posedge pclk) begin
      if (push) stat_mem[wr_ptr_r] <= stat_w;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         ovr_r    <= 1'b0;
      end else begin
         if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
         if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
         count_r <= count_r + {2'h0, push} - {2'h0, pop};
         if (mac_done && await_r && full && discard_r) ovr_r <= 1'b1;
         else if (pop) ovr_r <= 1'b0;
      end
   end
   // host clears the error flag by writing one; a new error in that cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_r <= 1'b0;
      end else if ((wr_data && st_r == S_CMDB && (len_bad || cmdb_bad)) ||
                   (mac_done && await_r && full && !discard_r)) begin
         err_r <= 1'b1;
      end else if (done_x && pwrite && paddr == OFS_INFO && pwdata[INFO_ERR_BIT]) begin
         err_r <= 1'b0;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) used_r <= 3'h0;
      else used_r <= ovr_r ? 3'h0 : count_r;
   end
   assign prdata                 = prdata_r;
   assign pready                 = pready_r;
   assign pslverr                = pslverr_r;
   assign mac_data               = mac_data_r;
   assign mac_be                 = mac_be_r;
   assign mac_valid              = mac_valid_r;
   assign mac_last               = mac_last_r;
   assign mac_no_crc             = no_crc_r;
   assign mac_no_pad             = no_pad_r;
   assign transmit_error_flag    = err_r;
   assign status_fifo_used_count = used_r;

   //////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_last_out;
      mac_valid_r && mac_ready && mac_last_r;
   endsequence
   sequence s_done_push;
      mac_done && push;
   endsequence

   a_tag_status: assert property (@(posedge pclk) disable iff (!presetn)
      s_last_out ##[1:16] s_done_push |=> stat_mem[$past(wr_ptr_r)][31:16] == $past(cmdb_r[B_TAG_LSB +: 16]))
      else $error("status tag differs from packet tag");
   a_crc_pad_ctl: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_data && st_r == S_DATA) |=> no_crc_r == (cmdb_r[13] && !cmdb_r[12]) && no_pad_r == cmdb_r[12])
      else $error("fcs or pad control wrong");
   a_len_error: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_data && st_r == S_CMDB && len_bad) |=> err_r)
      else $error("length mismatch not flagged");
   a_skip_drop: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_data && (st_r == S_SKIP || st_r == S_PAD)) |=> !$rose(mac_valid_r))
      else $error("offset or pad dword forwarded");
   a_first_lane: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_data && st_r == S_DATA && first_r && cnt_r != 11'h001) |=> mac_be_r == 4'((4'hF << $past(cmda_r[17:16]))))
      else $error("first byte lane wrong");
   a_suspend_tx: assert property (@(posedge pclk) disable iff (!presetn)
      (full && !discard_r && acc && pwrite && paddr == OFS_DATA && !pready_r) |=> !pready_r)
      else $error("data accepted with full status queue");
   a_ovr_used: assert property (@(posedge pclk) disable iff (!presetn)
      (ovr_r && $past(ovr_r)) |-> used_r == 3'h0)
      else $error("used count not zero on overrun");
   a_ovr_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      (mac_done && await_r && full && discard_r && !err_r) |=> !err_r)
      else $error("discard overrun raised error");
   a_es_summary: assert property (@(posedge pclk) disable iff (!presetn)
      s_done_push |=> stat_mem[$past(wr_ptr_r)][15] == |{$past(mac_lost_carrier), $past(mac_no_carrier),
         $past(mac_late_col), $past(mac_excess_col), $past(mac_excess_defer && defer_check_enable)})
      else $error("error summary wrong");
   a_push_cause: assert property (@(posedge pclk) disable iff (!presetn)
      (count_r > $past(count_r)) |-> $past(mac_done))
      else $error("status pushed without completion");
endmodule : tx_command_data_status_path

// ### mac_tx_model.sv
// mac transmit side model: takes words with optional stalls, then reports packet status
`timescale 1ns/1ps
module mac_tx_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       slow,
   input  wire logic       mac_valid,
   input  wire logic       mac_last,
   input  wire logic [9:0] st_in,
   output logic            mac_ready,
   output logic            mac_done,
   output logic      [9:0] st_out
);
   logic [3:0] cnt_r;
   logic       wait_r;
   //////////////////////////////////////////////////////////////////////////////
   // slow mode accepts one word in four and reports late, so back-pressure is exercised
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r    <= 4'h0;
         wait_r   <= 1'b0;
         mac_done <= 1'b0;
      end else begin
         cnt_r    <= cnt_r + 4'h1;
         mac_done <= 1'b0;
         if (mac_valid && mac_ready && mac_last) begin
            wait_r <= 1'b1;
            cnt_r  <= 4'h0;
         end else if (wait_r && cnt_r == (slow ? 4'hc : 4'h3)) begin
            wait_r   <= 1'b0;
            mac_done <= 1'b1;
         end
      end
   end
   assign mac_ready = slow ? (cnt_r[1:0] == 2'h3) : 1'b1;
   // status lines only mean something with the done pulse; inverted otherwise
   assign st_out = mac_done ? st_in : ~st_in;
endmodule : mac_tx_model

// ### tx_command_data_status_path_tb_top.sv
// self-checking bench for the transmit command, data and status path
`timescale 1ns/1ps
module tx_command_data_status_path_tb_top;
   import tx_path_pkg::*;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0000_0000;
   logic        slow     = 1'b0;
   logic        chk      = 1'b0;
   logic [9:0]  st_in    = 10'h000;
   logic [31:0] prdata, mac_data;
   logic [3:0]  mac_be;
   logic [2:0]  status_fifo_used_count;
   logic [9:0]  st_out;
   logic        pready, pslverr, mac_valid, mac_last, mac_no_crc, mac_no_pad;
   logic        mac_ready, mac_done, transmit_error_flag;
   logic [38:0] mac_q[$];
   logic [32:0] apb_q[$];
   logic [31:0] st_q[$];
   int          err_count   = 0;
   int          checks_done = 0;
   int          done_cnt    = 0;
   int          seed        = 32'hecf1;
   always #4 pclk = ~pclk;
   tx_command_data_status_path i_tx_command_data_status_path (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mac_data(mac_data), .mac_be(mac_be), .mac_valid(mac_valid), .mac_last(mac_last),
      .mac_no_crc(mac_no_crc), .mac_no_pad(mac_no_pad), .mac_ready(mac_ready), .mac_done(mac_done),
      .mac_lost_carrier(st_out[9]), .mac_no_carrier(st_out[8]), .mac_late_col(st_out[7]),
      .mac_excess_col(st_out[6]), .mac_col_count(st_out[5:2]), .mac_excess_defer(st_out[1]),
      .mac_deferred(st_out[0]), .defer_check_enable(chk), .transmit_error_flag(transmit_error_flag),
      .status_fifo_used_count(status_fifo_used_count));
   mac_tx_model i_mac_tx_model (.pclk(pclk), .presetn(presetn), .slow(slow), .mac_valid(mac_valid),
      .mac_last(mac_last), .st_in(st_in), .mac_ready(mac_ready), .mac_done(mac_done), .st_out(st_out));
   //////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] msk(input logic [3:0] be);
      return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : msk
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict
   task automatic cmp_val(input string what, input logic [38:0] e, input logic [38:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : cmp_val
   // one transfer, called just after an edge; the idle cycle at the end keeps drives single per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int n;
      n = 0;
      apb_q.push_back(e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 400);
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 400) begin
         err_count++;
         give_verdict();
      end
      @(posedge pclk);
   endtask : apb
   task automatic chk_ports(input logic e_err, input logic [2:0] e_cnt);
      repeat (2) @(posedge pclk);
      cmp_val("flag and count", 39'({e_err, e_cnt}), 39'({transmit_error_flag, status_fifo_used_count}));
   endtask : chk_ports
   task automatic rd_stat;
      apb(1'b0, OFS_STATUS, 32'h0, {1'b0, st_q.pop_front()});
   endtask : rd_stat
   task automatic send_buf(input logic [10:0] sz, input logic [4:0] off, input logic [1:0] al, input logic f,
                           input logic l, input logic [31:0] b);
      int nd, tot, am, p;
      logic [31:0] w;
      logic [3:0]  be;
      nd  = (int'(off[1:0]) + int'(sz) + 3) / 4;
      tot = int'(off[4:2]) + nd;
      am  = (al == 2'h1) ? 4 : ((al == 2'h2) ? 8 : 1);
      apb(1'b1, OFS_DATA, {6'h0, al, 3'h0, off, 2'h0, f, l, 1'b0, sz}, '0);
      apb(1'b1, OFS_DATA, b, '0);
      repeat (int'(off[4:2])) apb(1'b1, OFS_DATA, $random(seed), '0);
      for (int k = 0; k < nd; k++) begin
         w = $random(seed);
         for (int j = 0; j < 4; j++) begin
            p     = k * 4 + j;
            be[j] = (p >= int'(off[1:0])) && (p < int'(off[1:0]) + int'(sz));
         end
         mac_q.push_back({b[13] & !b[12], b[12], l && (k == nd - 1), be, w & msk(be)});
         apb(1'b1, OFS_DATA, w, '0);
      end
      repeat ((am - tot % am) % am) apb(1'b1, OFS_DATA, $random(seed), '0);
   endtask : send_buf
   task automatic send_pkt(input int nb, input logic [1:0] al, input int bad);
      logic [10:0] sz[3];
      logic [31:0] b;
      logic [15:0] tag;
      int          tot, n, want;
      logic [9:0]  s;
      logic        c;
      tot = 0;
      for (int k = 0; k < nb; k++) begin
         sz[k] = 11'd4 + 11'($random(seed) & 31);
         tot += int'(sz[k]);
      end
      tag   = 16'($random(seed));
      b     = {tag, 2'h0, 2'($random(seed)), 1'b0, 11'(tot + bad)};
      s     = 10'($random(seed));
      c     = 1'($random(seed));
      st_in <= s;
      chk   <= c;
      st_q.push_back({tag, |{s[9:6], s[1] & c}, 3'h0, s[9:6], 1'b0, s[5:2], s[1] & c,
                      1'b0, s[0]});
      want = done_cnt + 1;
      for (int k = 0; k < nb; k++)
         send_buf(sz[k], 5'($random(seed)), al, k == 0, k == nb - 1, b);
      n = 0;
      while (done_cnt < want && n < 400) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 400) begin
         err_count++;
         give_verdict();
      end
   endtask : send_pkt
   //////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin : watch
      logic [38:0] e;
      if (mac_done === 1'b1)
         done_cnt++;
      if (psel && penable && pready === 1'b1) begin
         e = (apb_q.size() > 0) ? 39'(apb_q.pop_front()) : '1;
         cmp_val("apb", e, {6'h0, pslverr, pwrite ? 32'h0 : prdata});
      end
      if (mac_valid === 1'b1 && mac_ready === 1'b1) begin
         e = (mac_q.size() > 0) ? mac_q.pop_front() : '1;
         cmp_val("mac", e, {mac_no_crc, mac_no_pad, mac_last, mac_be, mac_data & msk(mac_be)});
      end
   end
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, OFS_CFG, 32'h0, {1'b0, 31'h0, CFG_RESET});
      apb(1'b0, OFS_INFO, 32'h0, '0);
      apb(1'b0, OFS_STATUS, 32'h0, '0);
      apb(1'b0, 8'h10, 32'h0, {1'b1, 32'h0});
      apb(1'b1, 8'h14, 32'hffff_ffff, {1'b1, 32'h0});
      chk_ports(1'b0, 3'h0);
      $display("test reset done");
      // every alignment code, one to three buffers, prompt and stalling mac
      for (int i = 0; i < 4; i++) begin
         slow <= i[0];
         send_pkt(i % 3 + 1, 2'(i), 0);
      end
      chk_ports(1'b0, 3'h4);
      apb(1'b0, OFS_INFO, 32'h0, {1'b0, 32'h0000_0400});
      repeat (4) rd_stat();
      apb(1'b0, OFS_STATUS, 32'h0, '0);
      $display("test packets done");
      send_pkt(2, 2'h1, 3);
      chk_ports(1'b1, 3'h1);
      apb(1'b1, OFS_INFO, 32'h1, '0);
      chk_ports(1'b0, 3'h1);
      rd_stat();
      $display("test length done");
      apb(1'b1, OFS_CFG, 32'h1, '0);
      apb(1'b0, OFS_CFG, 32'h0, {1'b0, 32'h1});
      for (int i = 0; i < 5; i++)
         send_pkt(1, 2'h2, 0);
      void'(st_q.pop_back());
      chk_ports(1'b0, 3'h0);
      repeat (4) rd_stat();
      apb(1'b0, OFS_STATUS, 32'h0, '0);
      $display("test overrun done");
      cmp_val("left over", 39'(mac_q.size() + apb_q.size()), 39'h0);
      give_verdict();
   end
endmodule : tx_command_data_status_path_tb_top
